// *** toc_pkg.sv ***
package toc_pkg;
  // ==========================================
  // counter limits
  localparam logic [7:0] TOC_BOTTOM = 8'h00;
  localparam logic [7:0] TOC_MAX = 8'hff;
  // ==========================================
  // reset values
  localparam logic [7:0] TOC_COUNT_RST = 8'h00;
  localparam logic [7:0] TOC_CMP_RST = 8'h00;
  localparam logic TOC_OUT_RST = 1'b0;
  // ==========================================
  // waveform modes (3-bit select)
  localparam logic [2:0] TOC_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TOC_WGM_PC_FF = 3'h1;
  localparam logic [2:0] TOC_WGM_CTC = 3'h2;
  localparam logic [2:0] TOC_WGM_FAST_FF = 3'h3;
  localparam logic [2:0] TOC_WGM_PC_CMP = 3'h5;
  localparam logic [2:0] TOC_WGM_FAST_CMP = 3'h7;
  // ==========================================
  // output action codes
  localparam logic [1:0] TOC_ACT_NONE = 2'h0;
  localparam logic [1:0] TOC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TOC_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TOC_ACT_SET = 2'h3;
endpackage : toc_pkg

// *** toc_unit.sv ***
`timescale 1ns/1ps
// Functional notes
// - compare count with both values continuously
// - match sets flag on next tick
// - flag cleared by service or write-one
// - buffer compare values in PWM modes
// - buffer copies at top or bottom only
// - cpu writes reach buffer or active register
// - force strobe acts like match outside pwm modes, no flag
// - count write blocks matches next tick
// - output state kept across mode change
// - output action unbuffered, applies next match
// - reset clears output state to zero
// - nonzero action overrides port output value
// - override depends only on action bits
// - action zero leaves output unchanged
// - action selects set/clear/toggle or polarity
// - action bits never alter counting
// - normal mode counts up, wraps ff to 00
// - overflow flag set on wrap from top to zero; dual slope sets it at bottom
// - normal mode accepts count writes anytime
// - max ff, bottom 00
// - cpu count write beats count/clear
module toc_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic timer_tick,
  input wire logic [2:0] waveform_mode_select,
  input wire logic [1:0] output_action_select_a,
  input wire logic [1:0] output_action_select_b,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic cmp_a_wr,
  input wire logic cmp_b_wr,
  input wire logic [7:0] cmp_wdata,
  input wire logic force_match_strobe_a,
  input wire logic force_match_strobe_b,
  input wire logic flag_a_clr,
  input wire logic flag_b_clr,
  input wire logic ovf_clr,
  input wire logic port_value_a,
  input wire logic port_value_b,
  input wire logic output_pin_direction_bit_a,
  input wire logic output_pin_direction_bit_b,
  output logic [7:0] timer_count,
  output logic [7:0] compare_value_a,
  output logic [7:0] compare_value_b,
  output logic match_flag_a,
  output logic match_flag_b,
  output logic overflow_flag,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);

  // ==========================================
  // mode decode
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == toc_pkg::TOC_WGM_PC_FF) || (m == toc_pkg::TOC_WGM_FAST_FF) ||
             (m == toc_pkg::TOC_WGM_PC_CMP) || (m == toc_pkg::TOC_WGM_FAST_CMP);
  endfunction : is_pwm

  function automatic logic is_fast(input logic [2:0] m);
    is_fast = (m == toc_pkg::TOC_WGM_FAST_FF) || (m == toc_pkg::TOC_WGM_FAST_CMP);
  endfunction : is_fast

  // next output state for a non-pwm match
  function automatic logic act_next(input logic [1:0] act, input logic cur);
    case (act)
      toc_pkg::TOC_ACT_TOGGLE: act_next = ~cur;
      toc_pkg::TOC_ACT_CLEAR: act_next = 1'b0;
      toc_pkg::TOC_ACT_SET: act_next = 1'b1;
      default: act_next = cur;
    endcase
  endfunction : act_next

  // ==========================================
  // state and next-state values
  logic [7:0] count_q, count_d;
  logic up_q, up_d;
  logic block_q, block_d;
  logic [7:0] act_a_q, act_a_d, act_b_q, act_b_d;
  logic [7:0] buf_a_q, buf_a_d, buf_b_q, buf_b_d;
  logic flag_a_q, flag_a_d, flag_b_q, flag_b_d, ovf_q, ovf_d;
  logic oc_a_q, oc_a_d, oc_b_q, oc_b_d;
  logic pa_out_q, pa_out_d, pa_oe_q, pa_oe_d, pb_out_q, pb_out_d, pb_oe_q, pb_oe_d;
  logic pwm, fast, top_is_cmp, match_a, match_b, at_top, at_bottom;
  logic [7:0] top_val;

  // ==========================================
  // compare and counting
  always_comb begin
    pwm = is_pwm(waveform_mode_select);
    fast = is_fast(waveform_mode_select);
    top_is_cmp = waveform_mode_select[2];
    top_val = top_is_cmp ? act_a_q : toc_pkg::TOC_MAX;
    match_a = (count_q == act_a_q) && !block_q;
    match_b = (count_q == act_b_q) && !block_q;
    at_top = (count_q == top_val);
    at_bottom = (count_q == toc_pkg::TOC_BOTTOM);
    count_d = count_q;
    up_d = up_q;
    // block lasts until the tick after the write, even if stopped
    block_d = block_q;
    if (timer_tick) begin
      block_d = 1'b0;
    end
    if (count_wr) begin
      block_d = 1'b1;
    end
    // action bits play no part here
    if (timer_tick) begin
      case (waveform_mode_select)
        toc_pkg::TOC_WGM_NORMAL: count_d = count_q + 8'h01;
        toc_pkg::TOC_WGM_CTC: count_d = match_a ? toc_pkg::TOC_BOTTOM : count_q + 8'h01;
        toc_pkg::TOC_WGM_FAST_FF, toc_pkg::TOC_WGM_FAST_CMP:
          count_d = at_top ? toc_pkg::TOC_BOTTOM : count_q + 8'h01;
        toc_pkg::TOC_WGM_PC_FF, toc_pkg::TOC_WGM_PC_CMP: begin
          // dual slope turns round at top and at bottom
          if (up_q && at_top) begin
            up_d = 1'b0;
            count_d = count_q - 8'h01;
          end else if (!up_q && at_bottom) begin
            up_d = 1'b1;
            count_d = count_q + 8'h01;
          end else begin
            count_d = up_q ? count_q + 8'h01 : count_q - 8'h01;
          end
        end
        default: count_d = count_q + 8'h01;
      endcase
    end
    if (!pwm) begin
      up_d = 1'b1;
    end
    // applied last so a cpu write overrides any count or clear
    if (count_wr) begin
      count_d = count_wdata;
    end
  end

  // ==========================================
  // compare registers and buffers
  always_comb begin
    act_a_d = act_a_q;
    act_b_d = act_b_q;
    buf_a_d = buf_a_q;
    buf_b_d = buf_b_q;
    if (pwm) begin
      // cpu writes reach only the buffer; the live value moves at the update point
      if (cmp_a_wr) begin
        buf_a_d = cmp_wdata;
      end
      if (cmp_b_wr) begin
        buf_b_d = cmp_wdata;
      end
      // a write in the update cycle waits for the next update point
      // update at top for fast, bottom for dual slope
      if (timer_tick && (fast ? at_top : (at_bottom && !up_q))) begin
        act_a_d = buf_a_q;
        act_b_d = buf_b_q;
      end
    end else begin
      // buffer follows too, so entering pwm starts from the live value
      if (cmp_a_wr) begin
        act_a_d = cmp_wdata;
        buf_a_d = cmp_wdata;
      end
      if (cmp_b_wr) begin
        act_b_d = cmp_wdata;
        buf_b_d = cmp_wdata;
      end
    end
  end

  // ==========================================
  // flags: hardware set wins over clear
  always_comb begin
    flag_a_d = flag_a_q & ~flag_a_clr;
    flag_b_d = flag_b_q & ~flag_b_clr;
    ovf_d = ovf_q & ~ovf_clr;
    if (timer_tick && match_a) begin
      flag_a_d = 1'b1;
    end
    if (timer_tick && match_b) begin
      flag_b_d = 1'b1;
    end
    // a write on the same tick owns the counter, so no overflow is seen
    if (timer_tick && !count_wr) begin
      if ((pwm && !fast) ? (at_bottom && !up_q) : (count_d == toc_pkg::TOC_BOTTOM && at_top)) begin
        ovf_d = 1'b1;
      end
    end
  end

  // ==========================================
  // output state; mode changes do not touch it
  always_comb begin
    oc_a_d = oc_a_q;
    oc_b_d = oc_b_q;
    if (!pwm) begin
      // action bits read live, so a new setting hits the next match
      if ((timer_tick && match_a) || force_match_strobe_a) begin
        oc_a_d = act_next(output_action_select_a, oc_a_q);
      end
      if ((timer_tick && match_b) || force_match_strobe_b) begin
        oc_b_d = act_next(output_action_select_b, oc_b_q);
      end
    end else if (timer_tick) begin
      // force strobes have no effect in pwm modes
      // polarity: code 2 clears on match, code 3 sets
      if (output_action_select_a[1]) begin
        if (match_a && (fast || up_q)) begin
          oc_a_d = output_action_select_a[0];
        end else if (match_a) begin
          oc_a_d = ~output_action_select_a[0];
        end else if (fast && at_top) begin
          oc_a_d = ~output_action_select_a[0];
        end
      end else if (output_action_select_a == toc_pkg::TOC_ACT_TOGGLE
                   && top_is_cmp && match_a) begin
        // toggle exists only on channel a, with top taken from compare a
        oc_a_d = ~oc_a_q;
      end
      if (output_action_select_b[1]) begin
        if (match_b && (fast || up_q)) begin
          oc_b_d = output_action_select_b[0];
        end else if (match_b) begin
          oc_b_d = ~output_action_select_b[0];
        end else if (fast && at_top) begin
          oc_b_d = ~output_action_select_b[0];
        end
      end
    end
    // port override, independent of mode
    // pins take the next state, so they do not lag the state register
    pa_out_d = (output_action_select_a != toc_pkg::TOC_ACT_NONE) ? oc_a_d
               : port_value_a;
    pb_out_d = (output_action_select_b != toc_pkg::TOC_ACT_NONE) ? oc_b_d
               : port_value_b;
    pa_oe_d = output_pin_direction_bit_a;
    pb_oe_d = output_pin_direction_bit_b;
  end

  // ==========================================
  // registers
  // synchronous reset only; pins are unknown until reset is seen, then undriven
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= toc_pkg::TOC_COUNT_RST;
      up_q <= 1'b1;
      block_q <= 1'b0;
      act_a_q <= toc_pkg::TOC_CMP_RST;
      act_b_q <= toc_pkg::TOC_CMP_RST;
      buf_a_q <= toc_pkg::TOC_CMP_RST;
      buf_b_q <= toc_pkg::TOC_CMP_RST;
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
      ovf_q <= 1'b0;
      oc_a_q <= toc_pkg::TOC_OUT_RST;
      oc_b_q <= toc_pkg::TOC_OUT_RST;
      pa_out_q <= 1'b0;
      pa_oe_q <= 1'b0;
      pb_out_q <= 1'b0;
      pb_oe_q <= 1'b0;
    end else begin
      count_q <= count_d;
      up_q <= up_d;
      block_q <= block_d;
      act_a_q <= act_a_d;
      act_b_q <= act_b_d;
      buf_a_q <= buf_a_d;
      buf_b_q <= buf_b_d;
      flag_a_q <= flag_a_d;
      flag_b_q <= flag_b_d;
      ovf_q <= ovf_d;
      oc_a_q <= oc_a_d;
      oc_b_q <= oc_b_d;
      pa_out_q <= pa_out_d;
      pa_oe_q <= pa_oe_d;
      pb_out_q <= pb_out_d;
      pb_oe_q <= pb_oe_d;
    end
  end

  // ==========================================
  // outputs, each straight from a register
  assign timer_count = count_q;
  assign compare_value_a = act_a_q;
  assign compare_value_b = act_b_q;
  assign match_flag_a = flag_a_q;
  assign match_flag_b = flag_b_q;
  assign overflow_flag = ovf_q;
  assign compare_output_a = oc_a_q;
  assign compare_output_b = oc_b_q;
  assign pin_a_out = pa_out_q;
  assign pin_a_oe = pa_oe_q;
  assign pin_b_out = pb_out_q;
  assign pin_b_oe = pb_oe_q;

endmodule : toc_unit

// *** toc_unit_chk.sv ***
`timescale 1ns/1ps
module toc_unit_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic timer_tick,
  input wire logic [2:0] waveform_mode_select,
  input wire logic [1:0] output_action_select_a,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic force_match_strobe_a,
  input wire logic flag_a_clr,
  input wire logic port_value_a,
  input wire logic output_pin_direction_bit_a,
  input wire logic [7:0] timer_count,
  input wire logic [7:0] compare_value_a,
  input wire logic match_flag_a,
  input wire logic overflow_flag,
  input wire logic compare_output_a,
  input wire logic pin_a_out,
  input wire logic pin_a_oe
);
  // ====
  // helpers
  logic blk_q, blk_d, hit, norm;
  // a count write shuts matches until its next tick is over
  always_comb begin
    blk_d = count_wr | (blk_q & ~timer_tick);
  end
  always_ff @(posedge clk) begin
    blk_q <= srst ? 1'b0 : blk_d;
  end
  // a tick landing on the compare value, and the plain counting mode
  assign hit = timer_tick & (timer_count == compare_value_a);
  assign norm = waveform_mode_select == toc_pkg::TOC_WGM_NORMAL;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ====
  // checks
  a_flag_on_match: assert property (hit && !blk_q && !count_wr |=> match_flag_a)
    else $error("flag a not set");
  a_match_blocked: assert property (timer_tick && blk_q && !match_flag_a |=> !match_flag_a)
    else $error("blocked match set flag a");
  a_force_no_flag: assert property (force_match_strobe_a && !hit && !match_flag_a
    |=> !match_flag_a)
    else $error("force set flag a");
  a_flag_clear: assert property (flag_a_clr && !hit |=> !match_flag_a)
    else $error("flag a not cleared");
  a_count_step: assert property (norm && timer_tick && !count_wr
    |=> timer_count == 8'($past(timer_count) + 8'h01))
    else $error("count step wrong");
  a_wrap_ovf: assert property (norm && timer_tick && !count_wr && timer_count == 8'hff
    |=> overflow_flag && timer_count == 8'h00)
    else $error("wrap or overflow wrong");
  a_count_write: assert property (count_wr |=> timer_count == $past(count_wdata))
    else $error("count write lost");
  // the pin register loads the next output state, so pin and state move together
  a_pin_route: assert property (1'b1
    |=> pin_a_out == (($past(output_action_select_a) != 2'h0)
    ? compare_output_a : $past(port_value_a))
    && pin_a_oe == $past(output_pin_direction_bit_a))
    else $error("pin a route wrong");
  a_oc_hold: assert property (output_action_select_a == 2'h0
    |=> $stable(compare_output_a))
    else $error("oc a moved with no action");
endmodule : toc_unit_chk

bind toc_unit toc_unit_chk toc_unit_chk_i (.clk, .srst, .timer_tick, .waveform_mode_select,
  .output_action_select_a, .count_wr, .count_wdata, .force_match_strobe_a, .flag_a_clr,
  .port_value_a, .output_pin_direction_bit_a, .timer_count, .compare_value_a,
  .match_flag_a, .overflow_flag, .compare_output_a, .pin_a_out, .pin_a_oe);

// *** toc_cpu_model.sv ***
`timescale 1ns/1ps
module toc_cpu_model (
  input wire logic clk,
  output logic [8:0] stb,
  output logic [7:0] wdata
);
  // ====
  // io write strobes
  initial begin
    stb = 9'h000;
    wdata = 8'h00;
  end
  // data scrambled on release so nothing leans on a stale byte
  task automatic strobe(input int idx, input logic [7:0] v);
    @(posedge clk);
    #1;
    stb[idx] = 1'b1;
    wdata = v;
    @(posedge clk);
    #1;
    stb = 9'h000;
    wdata = ~v;
  endtask : strobe
endmodule : toc_cpu_model

// *** toc_unit_tb_top.sv ***
`timescale 1ns/1ps
module toc_unit_tb_top;
  localparam int TK = 0, CW = 1, AW = 2, BW = 3, FA = 4, FB = 5, CA = 6, CB = 7, CO = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [8:0] stb;
  logic [7:0] wdata, timer_count, compare_value_a, compare_value_b;
  logic [2:0] mode = 3'h0;
  logic [1:0] act_a = 2'h0, act_b = 2'h0;
  logic port_a = 1'b0, port_b = 1'b0, dir_a = 1'b0, dir_b = 1'b0;
  logic match_flag_a, match_flag_b, overflow_flag, compare_output_a, compare_output_b;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  logic [1:0] acts [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
  logic [4:0] exp_oc = 5'h19;
  int n_fail = 0, n_compared = 0;
  always #5 clk = ~clk;
  toc_cpu_model toc_cpu_model_i (.clk, .stb, .wdata);
  toc_unit toc_unit_i (.clk, .srst, .timer_tick(stb[TK]), .waveform_mode_select(mode),
    .output_action_select_a(act_a), .output_action_select_b(act_b), .count_wr(stb[CW]),
    .count_wdata(wdata), .cmp_a_wr(stb[AW]), .cmp_b_wr(stb[BW]), .cmp_wdata(wdata),
    .force_match_strobe_a(stb[FA]), .force_match_strobe_b(stb[FB]), .flag_a_clr(stb[CA]),
    .flag_b_clr(stb[CB]), .ovf_clr(stb[CO]), .port_value_a(port_a), .port_value_b(port_b),
    .output_pin_direction_bit_a(dir_a), .output_pin_direction_bit_b(dir_b), .timer_count,
    .compare_value_a, .compare_value_b, .match_flag_a, .match_flag_b, .overflow_flag,
    .compare_output_a, .compare_output_b, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe);
  // ====
  // tasks
  task automatic s(input int i, input logic [7:0] v = 8'h00);
    toc_cpu_model_i.strobe(i, v);
  endtask : s
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // watchdog, far beyond the roughly 60 cycles the tests need
  initial begin
    #5000;
    n_fail++;
    summarize();
  end
  // ====
  // tests
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    chk("oc_a", toc_pkg::TOC_OUT_RST, compare_output_a);
    chk("oc_b", toc_pkg::TOC_OUT_RST, compare_output_b);
    act_b = toc_pkg::TOC_ACT_TOGGLE;
    s(AW, 8'h05);
    chk("cmp_a", 8'h05, compare_value_a);
    s(BW, 8'h06);
    chk("cmp_b", 8'h06, compare_value_b);
    s(CW, 8'h04);
    s(CA);
    s(CB);
    s(TK);
    s(TK);
    chk("flag_a", 8'h01, match_flag_a);
    chk("flag_b", 8'h00, match_flag_b);
    s(TK);
    chk("flag_b", 8'h01, match_flag_b);
    chk("pin_b", 8'h01, pin_b_out);
    chk("oe_b", 8'h00, pin_b_oe);
    chk("oc_b", 8'h01, compare_output_b);
    chk("oc_a", 8'h00, compare_output_a);
    chk("count", 8'h07, timer_count);
    s(CA);
    chk("flag_a", 8'h00, match_flag_a);
    // a count write equal to the compare value swallows that match
    s(CW, 8'h05);
    s(TK);
    chk("flag_a", 8'h00, match_flag_a);
    chk("count", 8'h06, timer_count);
    s(CW, toc_pkg::TOC_MAX);
    s(CO);
    s(TK);
    chk("count", toc_pkg::TOC_BOTTOM, timer_count);
    chk("ovf", 8'h01, overflow_flag);
    s(CO);
    chk("ovf", 8'h00, overflow_flag);
    // every action code through the force strobe, no ticks meanwhile
    for (int i = 0; i < 5; i++) begin
      act_a = acts[i];
      s(FA);
      chk("oc_a", {7'h00, exp_oc[i]}, compare_output_a);
    end
    chk("flag_a", 8'h00, match_flag_a);
    dir_a = 1'b1;
    @(posedge clk);
    #1;
    chk("pin_a", 8'h00, pin_a_out);
    chk("oe_a", 8'h01, pin_a_oe);
    act_a = toc_pkg::TOC_ACT_SET;
    mode = toc_pkg::TOC_WGM_FAST_FF;
    repeat (2) @(posedge clk);
    #1;
    chk("oc_a", 8'h01, compare_output_a);
    chk("pin_a", 8'h01, pin_a_out);
    act_a = toc_pkg::TOC_ACT_CLEAR;
    s(FA);
    chk("oc_a", 8'h01, compare_output_a);
    // buffered compare loads only at the top of the sequence
    s(AW, 8'h20);
    chk("cmp_a", 8'h05, compare_value_a);
    s(CW, toc_pkg::TOC_MAX);
    s(TK);
    chk("cmp_a", 8'h20, compare_value_a);
    // clear-on-match: compare writes go straight through, a match clears the count
    mode = toc_pkg::TOC_WGM_CTC;
    s(AW, 8'h03);
    chk("cmp_a", 8'h03, compare_value_a);
    s(CW, 8'h02);
    s(TK);
    s(TK);
    chk("count", toc_pkg::TOC_BOTTOM, timer_count);
    chk("flag_a", 8'h01, match_flag_a);
    chk("oc_a", 8'h00, compare_output_a);
    summarize();
  end
endmodule : toc_unit_tb_top
